//--- include/rri_pkg.sv
// Package for the return and software-reset execution block.
// Assumes the fetch stage delivers one 16-bit instruction word per instruction cycle.
package rri_pkg;

   // ==========================================================================
   // Widths and sizes
   localparam int unsigned PC_W        = 21;
   localparam int unsigned DATA_W      = 8;
   localparam int unsigned INSTR_W     = 16;
   localparam int unsigned STACK_DEPTH = 31;
   localparam int unsigned LEVEL_W     = 5;

   // ==========================================================================
   // Quarter-cycle phases of one instruction cycle
   localparam logic [1:0] Q1 = 2'h0;
   localparam logic [1:0] Q2 = 2'h1;
   localparam logic [1:0] Q3 = 2'h2;
   localparam logic [1:0] Q4 = 2'h3;

   // ==========================================================================
   // Opcodes and field positions
   localparam logic [15:0] OP_SOFT_RESET    = 16'h00FF;
   localparam logic [15:0] OP_IRQ_RET_BASE  = 16'h0010;
   localparam logic [15:0] OP_IRQ_RET_MASK  = 16'hFFFE;
   localparam logic [7:0]  OP_LIT_RET_HIGH  = 8'h0C;
   localparam int unsigned SHADOW_FLAG_BIT  = 0;

   // ==========================================================================
   // Values after reset
   localparam logic [PC_W-1:0]   PC_RESET     = 21'h000000;
   localparam logic [DATA_W-1:0] W_RESET      = 8'h00;
   localparam logic [DATA_W-1:0] STATUS_RESET = 8'h00;
   localparam logic [DATA_W-1:0] BANK_RESET   = 8'h00;
   localparam logic [DATA_W-1:0] LATCH_RESET  = 8'h00;
   localparam logic [LEVEL_W-1:0] LEVEL_RESET = 5'h00;

   // ==========================================================================
   // Types
   typedef enum logic [1:0] {
      RRI_IDLE  = 2'b00,
      RRI_EXEC1 = 2'b01,
      RRI_EXEC2 = 2'b11
   } rri_state_t;

   typedef struct packed {
      logic [DATA_W-1:0] working;
      logic [DATA_W-1:0] status;
      logic [DATA_W-1:0] bank_select;
   } rri_ctx_t;

   typedef struct packed {
      logic [LEVEL_W-1:0] ptr;
      logic [PC_W-1:0]    top;
   } rri_stack_st_t;

   typedef struct packed {
      logic [1:0]         phase;
      rri_state_t         state;
      logic               busy;
      logic [INSTR_W-1:0] instr;
      rri_ctx_t           ctx;
      logic [PC_W-1:0]    pc;
      logic               global_high_irq_enable;
      logic               peripheral_low_irq_enable;
      logic [DATA_W-1:0]  pc_high_latch;
      logic [DATA_W-1:0]  pc_upper_latch;
      logic               soft_reset;
   } rri_core_st_t;

endpackage

//--- hdl/rri_stack.sv
// Hardware return stack with a registered top entry.
// Assumes push and pop come from logic on the same clock; pop wins over push.
`timescale 1ns/1ps

module rri_stack #(
   parameter int unsigned DEPTH = rri_pkg::STACK_DEPTH,
   parameter int unsigned AW    = rri_pkg::PC_W
) (
   input  wire logic                         ref_clk_i,
   input  wire logic                         rst_n_i,
   input  wire logic                         flush_i,
   input  wire logic                         push_i,
   input  wire logic [AW-1:0]                push_data_i,
   input  wire logic                         pop_i,
   output logic      [AW-1:0]                top_o,
   output logic      [rri_pkg::LEVEL_W-1:0]  level_o
);

   // ==========================================================================
   // State
   rri_pkg::rri_stack_st_t s_r;
   rri_pkg::rri_stack_st_t s_nxt;
   logic [AW-1:0]          mem [DEPTH];
   logic [rri_pkg::LEVEL_W-1:0] below;

   // Entry just under the top; only read when the pointer is nonzero.
   assign below = s_r.ptr - 5'h01;

   // Pointer and top move together; an empty pop returns zero and keeps the level.
   always_comb begin
      s_nxt = s_r;
      if (flush_i) begin
         s_nxt.ptr = rri_pkg::LEVEL_RESET;
         s_nxt.top = rri_pkg::PC_RESET;
      end else if (pop_i) begin
         if (s_r.ptr != rri_pkg::LEVEL_RESET) begin
            s_nxt.ptr = below;
            s_nxt.top = mem[below];
         end else begin
            s_nxt.top = rri_pkg::PC_RESET;
         end
      end else if (push_i && (32'(s_r.ptr) < DEPTH)) begin
         s_nxt.ptr = s_r.ptr + 5'h01;
         s_nxt.top = push_data_i;
      end
   end

   // Lower entries need no reset; they are only read below a valid pointer.
   always_ff @(posedge ref_clk_i) begin
      if (!flush_i && !pop_i && push_i && (32'(s_r.ptr) < DEPTH)) begin
         mem[s_r.ptr] <= s_r.top;
      end
   end

   // State register.
   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         s_r <= '0;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign top_o   = s_r.top;
   assign level_o = s_r.ptr;

endmodule

//--- hdl/rri_core.sv
// Execution of the software reset and the two return instructions.
// Assumes a same-clock fetch stage and four clocks per instruction cycle.
`timescale 1ns/1ps

module rri_core (
   input  wire logic                          ref_clk_i,
   input  wire logic                          rst_n_i,
   input  wire logic [rri_pkg::INSTR_W-1:0]   instr_i,
   input  wire logic                          instr_valid_i,
   input  wire logic                          priority_en_i,
   input  wire logic                          active_high_level_i,
   input  wire logic                          irq_disable_i,
   input  wire rri_pkg::rri_ctx_t             shadow_i,
   input  wire logic                          latch_we_i,
   input  wire logic [rri_pkg::DATA_W-1:0]    pc_high_latch_i,
   input  wire logic [rri_pkg::DATA_W-1:0]    pc_upper_latch_i,
   input  wire logic                          push_i,
   input  wire logic [rri_pkg::PC_W-1:0]      push_addr_i,
   output logic      [1:0]                    q_phase_o,
   output logic                               busy_o,
   output rri_pkg::rri_ctx_t                  ctx_o,
   output logic      [rri_pkg::PC_W-1:0]      pc_o,
   output logic                               global_high_irq_enable_o,
   output logic                               peripheral_low_irq_enable_o,
   output logic      [rri_pkg::DATA_W-1:0]    pc_high_latch_o,
   output logic      [rri_pkg::DATA_W-1:0]    pc_upper_latch_o,
   output logic      [rri_pkg::PC_W-1:0]      return_stack_top_o,
   output logic      [rri_pkg::LEVEL_W-1:0]   stack_level_o,
   output logic                               soft_reset_o
);

   // ==========================================================================
   // Decode helpers
   function automatic logic is_soft_reset(input logic [15:0] op);
      return op == rri_pkg::OP_SOFT_RESET;
   endfunction

   function automatic logic is_irq_ret(input logic [15:0] op);
      return (op & rri_pkg::OP_IRQ_RET_MASK) == rri_pkg::OP_IRQ_RET_BASE;
   endfunction

   function automatic logic is_lit_ret(input logic [15:0] op);
      return op[15:8] == rri_pkg::OP_LIT_RET_HIGH;
   endfunction

   // ==========================================================================
   // State
   rri_pkg::rri_core_st_t s_r;
   rri_pkg::rri_core_st_t s_nxt;
   logic                  pop;
   logic                  flush;
   logic [rri_pkg::PC_W-1:0] stack_top;
   logic                  at_q4_exec1;
   logic                  accept;

   // The last quarter of the first cycle is where every return does its work.
   assign at_q4_exec1 = (s_r.state == rri_pkg::RRI_EXEC1) && (s_r.phase == rri_pkg::Q4);
   assign accept      = (s_r.state == rri_pkg::RRI_IDLE) && (s_r.phase == rri_pkg::Q1)
                        && instr_valid_i
                        && (is_soft_reset(instr_i) || is_irq_ret(instr_i) || is_lit_ret(instr_i));

   // Next-state logic; the phase counter keeps running through a software reset
   // so that the core stays aligned to its quarter cycles.
   always_comb begin
      s_nxt            = s_r;
      pop              = 1'b0;
      flush            = 1'b0;
      s_nxt.soft_reset = 1'b0;
      s_nxt.phase      = s_r.phase + 2'h1;
      // Clears are applied first so that a set in the same cycle wins.
      if (irq_disable_i) begin
         s_nxt.global_high_irq_enable    = 1'b0;
         s_nxt.peripheral_low_irq_enable = 1'b0;
      end
      if (latch_we_i) begin
         s_nxt.pc_high_latch  = pc_high_latch_i;
         s_nxt.pc_upper_latch = pc_upper_latch_i;
      end
      unique case (s_r.state)
         rri_pkg::RRI_IDLE: begin
            if (accept) begin
               s_nxt.instr = instr_i;
               s_nxt.state = rri_pkg::RRI_EXEC1;
            end
         end
         rri_pkg::RRI_EXEC1: begin
            if ((s_r.phase == rri_pkg::Q2) && is_soft_reset(s_r.instr)) begin
               // Everything a master clear touches returns to its reset value.
               s_nxt.state                     = rri_pkg::RRI_IDLE;
               s_nxt.ctx.working               = rri_pkg::W_RESET;
               s_nxt.ctx.status                = rri_pkg::STATUS_RESET;
               s_nxt.ctx.bank_select           = rri_pkg::BANK_RESET;
               s_nxt.pc                        = rri_pkg::PC_RESET;
               s_nxt.global_high_irq_enable    = 1'b0;
               s_nxt.peripheral_low_irq_enable = 1'b0;
               s_nxt.pc_high_latch             = rri_pkg::LATCH_RESET;
               s_nxt.pc_upper_latch            = rri_pkg::LATCH_RESET;
               s_nxt.soft_reset                = 1'b1;
               flush                           = 1'b1;
            end else if (s_r.phase == rri_pkg::Q4) begin
               // The latches are left alone here on purpose.
               pop         = 1'b1;
               s_nxt.pc    = stack_top;
               s_nxt.state = rri_pkg::RRI_EXEC2;
               if (is_lit_ret(s_r.instr)) begin
                  s_nxt.ctx.working = s_r.instr[7:0];
               end else begin
                  if (s_r.instr[rri_pkg::SHADOW_FLAG_BIT]) begin
                     s_nxt.ctx = shadow_i;
                  end
                  if (!priority_en_i || active_high_level_i) begin
                     s_nxt.global_high_irq_enable = 1'b1;
                  end else begin
                     s_nxt.peripheral_low_irq_enable = 1'b1;
                  end
               end
            end
         end
         rri_pkg::RRI_EXEC2: begin
            // Second cycle is a no-operation that ends with the cycle.
            if (s_r.phase == rri_pkg::Q4) begin
               s_nxt.state = rri_pkg::RRI_IDLE;
            end
         end
         default: begin
            s_nxt.state = rri_pkg::RRI_IDLE;
         end
      endcase
      s_nxt.busy = (s_nxt.state != rri_pkg::RRI_IDLE);
   end

   // State register.
   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         s_r <= '0;
      end else begin
         s_r <= s_nxt;
      end
   end

   // ==========================================================================
   // Return stack
   rri_stack #(
      .DEPTH (rri_pkg::STACK_DEPTH),
      .AW    (rri_pkg::PC_W)
   ) u_stack (
      .ref_clk_i   (ref_clk_i),
      .rst_n_i     (rst_n_i),
      .flush_i     (flush),
      .push_i      (push_i),
      .push_data_i (push_addr_i),
      .pop_i       (pop),
      .top_o       (stack_top),
      .level_o     (stack_level_o)
   );

   // Outputs straight from the state register; the stack top comes from the stack's own top register.
   assign q_phase_o                   = s_r.phase;
   assign busy_o                      = s_r.busy;
   assign ctx_o                       = s_r.ctx;
   assign pc_o                        = s_r.pc;
   assign global_high_irq_enable_o    = s_r.global_high_irq_enable;
   assign peripheral_low_irq_enable_o = s_r.peripheral_low_irq_enable;
   assign pc_high_latch_o             = s_r.pc_high_latch;
   assign pc_upper_latch_o            = s_r.pc_upper_latch;
   assign return_stack_top_o          = stack_top;
   assign soft_reset_o                = s_r.soft_reset;

   // ==========================================================================
   // Assertions
   default clocking cb @(posedge ref_clk_i); endclocking
   default disable iff (!rst_n_i);

   logic [7:0] lit_byte;
   logic       ret_op;
   logic       irq_ret_pop;
   assign lit_byte    = s_r.instr[7:0];
   assign ret_op      = !is_soft_reset(s_r.instr);
   assign irq_ret_pop = at_q4_exec1 && is_irq_ret(s_r.instr);

   soft_reset_q2_a: assert property (
      accept && is_soft_reset(instr_i) |-> ##2 (soft_reset_o && pc_o == rri_pkg::PC_RESET
         && stack_level_o == rri_pkg::LEVEL_RESET && !busy_o))
      else $error("software reset did not take effect in Q2");

   irq_ret_len_a: assert property (
      accept && is_irq_ret(instr_i) |-> ##1 busy_o [*7] ##1 !busy_o)
      else $error("interrupt return did not last two cycles");

   lit_ret_len_a: assert property (
      accept && is_lit_ret(instr_i) |-> ##4 (pc_o == $past(stack_top)) ##4 !busy_o)
      else $error("literal return pop or length wrong");

   irq_enable_set_a: assert property (
      irq_ret_pop |=> ((!$past(priority_en_i) || $past(active_high_level_i))
         ? global_high_irq_enable_o : peripheral_low_irq_enable_o))
      else $error("interrupt return did not set the right enable");

   shadow_restore_a: assert property (
      irq_ret_pop && s_r.instr[0] |=> ctx_o == $past(shadow_i))
      else $error("shadow copies not restored");

   shadow_keep_a: assert property (
      irq_ret_pop && !s_r.instr[0] |=> ctx_o == $past(ctx_o))
      else $error("context changed without shadow flag");

   literal_load_a: assert property (
      at_q4_exec1 && is_lit_ret(s_r.instr) |=> ctx_o.working == $past(lit_byte))
      else $error("literal not loaded into working register");

   latch_keep_a: assert property (
      at_q4_exec1 && ret_op && !latch_we_i |=> pc_high_latch_o == $past(pc_high_latch_o)
         && pc_upper_latch_o == $past(pc_upper_latch_o))
      else $error("return changed a program counter latch");

   stack_down_a: assert property (
      at_q4_exec1 && ret_op && stack_level_o != 5'h00
         |=> stack_level_o == $past(stack_level_o) - 5'h01)
      else $error("pop did not move the stack pointer down");

endmodule

//--- verification/test_return_and_reset_instr_exec.sv
// Self-checking bench for the return and software-reset execution core.
// Assumes rri_core and rri_stack are compiled first; no partner model is used.
`timescale 1ns/1ps

module test_return_and_reset_instr_exec;
   // =========================================================================
   // Stimulus and expectation state
   logic                 ref_clk_i           = 1'b0;
   logic                 rst_n_i             = 1'b0;
   logic [15:0]          instr_i             = 16'h0000;
   logic                 instr_valid_i       = 1'b0;
   logic                 priority_en_i       = 1'b0;
   logic                 active_high_level_i = 1'b0;
   logic                 irq_disable_i       = 1'b0;
   rri_pkg::rri_ctx_t    shadow_i            = 24'hE1E2E3;
   logic                 latch_we_i          = 1'b0;
   logic [7:0]           pc_high_latch_i     = 8'hA5;
   logic [7:0]           pc_upper_latch_i    = 8'h3C;
   logic                 push_i              = 1'b0;
   logic [20:0]          push_addr_i         = 21'h000000;
   logic [1:0]           q_phase_o;
   logic                 busy_o;
   rri_pkg::rri_ctx_t    ctx_o;
   logic [20:0]          pc_o;
   logic                 global_high_irq_enable_o;
   logic                 peripheral_low_irq_enable_o;
   logic [7:0]           pc_high_latch_o;
   logic [7:0]           pc_upper_latch_o;
   logic [20:0]          return_stack_top_o;
   logic [4:0]           stack_level_o;
   logic                 soft_reset_o;
   int                   mismatches          = 0;
   int                   n_checks            = 0;
   logic [20:0]          e_pc                = 21'h000000;
   rri_pkg::rri_ctx_t    e_ctx               = 24'h000000;
   logic                 e_gh                = 1'b0;
   logic                 e_pl                = 1'b0;
   logic [4:0]           e_lvl               = 5'h00;

   rri_core u_dut (
      .ref_clk_i                   (ref_clk_i),
      .rst_n_i                     (rst_n_i),
      .instr_i                     (instr_i),
      .instr_valid_i               (instr_valid_i),
      .priority_en_i               (priority_en_i),
      .active_high_level_i         (active_high_level_i),
      .irq_disable_i               (irq_disable_i),
      .shadow_i                    (shadow_i),
      .latch_we_i                  (latch_we_i),
      .pc_high_latch_i             (pc_high_latch_i),
      .pc_upper_latch_i            (pc_upper_latch_i),
      .push_i                      (push_i),
      .push_addr_i                 (push_addr_i),
      .q_phase_o                   (q_phase_o),
      .busy_o                      (busy_o),
      .ctx_o                       (ctx_o),
      .pc_o                        (pc_o),
      .global_high_irq_enable_o    (global_high_irq_enable_o),
      .peripheral_low_irq_enable_o (peripheral_low_irq_enable_o),
      .pc_high_latch_o             (pc_high_latch_o),
      .pc_upper_latch_o            (pc_upper_latch_o),
      .return_stack_top_o          (return_stack_top_o),
      .stack_level_o               (stack_level_o),
      .soft_reset_o                (soft_reset_o)
   );

   // =========================================================================
   // Clock and shared tasks
   // A 5 ns period gives the 200 MHz core clock.
   always #2.5 ref_clk_i = ~ref_clk_i;

   task automatic chk(input string nm, input logic [23:0] exp, input logic [23:0] got);
      n_checks++;
      if (got !== exp) begin
         mismatches++;
         $display("MISMATCH %s expected %h seen %h", nm, exp, got);
      end
   endtask

   // Offer the word so that the taking edge samples quarter Q1.
   task automatic issue(input logic [15:0] op);
      do begin
         @(posedge ref_clk_i);
         #1;
      end while (q_phase_o !== 2'h3);
      @(posedge ref_clk_i);
      instr_i       <= op;
      instr_valid_i <= 1'b1;
      @(posedge ref_clk_i);
      instr_valid_i <= 1'b0;
   endtask

   task automatic push(input logic [20:0] a);
      @(posedge ref_clk_i);
      push_i      <= 1'b1;
      push_addr_i <= a;
      @(posedge ref_clk_i);
      push_i      <= 1'b0;
      e_lvl++;
   endtask

   // Follows one return from its taking edge; the pop lands on the third edge after it,
   // where the first cycle's last quarter is sampled.
   task automatic ret_wait(input logic [20:0] new_pc, input logic [20:0] top);
      @(posedge ref_clk_i);
      #1;
      chk("busy_o", 1'b1, busy_o);
      @(posedge ref_clk_i);
      #1;
      chk("pc_o early", e_pc, pc_o);
      @(posedge ref_clk_i);
      #1;
      e_pc = new_pc;
      chk("pc_o", e_pc, pc_o);
      chk("ctx_o", e_ctx, ctx_o);
      chk("global_high", e_gh, global_high_irq_enable_o);
      chk("peripheral_low", e_pl, peripheral_low_irq_enable_o);
      chk("stack_level_o", e_lvl, stack_level_o);
      chk("stack top", top, return_stack_top_o);
      chk("pc_high_latch_o", 8'hA5, pc_high_latch_o);
      chk("pc_upper_latch_o", 8'h3C, pc_upper_latch_o);
      repeat (3) @(posedge ref_clk_i);
      #1;
      chk("busy_o second cycle", 1'b1, busy_o);
      @(posedge ref_clk_i);
      #1;
      chk("busy_o end", 1'b0, busy_o);
      chk("pc_o after nop", e_pc, pc_o);
   endtask

   // =========================================================================
   // Scenarios
   // Two pushes then a literal return: the deeper entry must surface.
   task automatic test_lit_ret;
      push(21'h00ABCD);
      push(21'h1F0002);
      e_ctx.working = 8'h5A;
      e_lvl--;
      issue(16'h0C5A);
      ret_wait(21'h1F0002, 21'h00ABCD);
      $display("test_lit_ret done");
   endtask

   // Each priority mode with the enables cleared first, shadow flag both ways.
   task automatic test_irq_ret;
      logic [2:0] pri;
      logic [2:0] hi;
      logic [2:0] sf;
      pri = 3'b110;
      hi  = 3'b010;
      sf  = 3'b101;
      for (int i = 0; i < 3; i++) begin
         @(posedge ref_clk_i);
         priority_en_i       <= pri[i];
         active_high_level_i <= hi[i];
         shadow_i            <= 24'hA0B0C0 + 24'(i);
         irq_disable_i       <= 1'b1;
         @(posedge ref_clk_i);
         irq_disable_i       <= 1'b0;
         push(21'h000100 + 21'(i));
         e_gh = !pri[i] || hi[i];
         e_pl = pri[i] && !hi[i];
         if (sf[i]) begin
            e_ctx = 24'hA0B0C0 + 24'(i);
         end
         e_lvl--;
         issue(16'h0010 | 16'(sf[i]));
         ret_wait(21'h000100 + 21'(i), 21'h00ABCD);
      end
      $display("test_irq_ret done");
   endtask

   // Everything left non-zero by earlier tests except the stack top must clear in the same pulse,
   // which stands for the one clock after the Q2 edge only.
   task automatic test_soft_reset;
      issue(16'h00FF);
      @(posedge ref_clk_i);
      #1;
      chk("soft_reset_o", 1'b1, soft_reset_o);
      chk("pc_o", 21'h000000, pc_o);
      chk("ctx_o", 24'h000000, ctx_o);
      chk("peripheral_low", 1'b0, peripheral_low_irq_enable_o);
      chk("pc_high_latch_o", 8'h00, pc_high_latch_o);
      chk("pc_upper_latch_o", 8'h00, pc_upper_latch_o);
      chk("stack_level_o", 5'h00, stack_level_o);
      chk("q_phase_o", 2'h2, q_phase_o);
      @(posedge ref_clk_i);
      #1;
      chk("soft_reset_o pulse", 1'b0, soft_reset_o);
      $display("test_soft_reset done");
   endtask

   // =========================================================================
   // Closing and main sequence
   task automatic final_report;
      $display("checks %0d mismatches %0d", n_checks, mismatches);
      if (mismatches == 0 && n_checks > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask

   // The tests need under a hundred cycles, so 5000 means a hang.
   initial begin
      repeat (5000) @(posedge ref_clk_i);
      mismatches++;
      final_report();
   end

   initial begin
      repeat (5) @(posedge ref_clk_i);
      rst_n_i    <= 1'b1;
      latch_we_i <= 1'b1;
      @(posedge ref_clk_i);
      latch_we_i <= 1'b0;
      test_lit_ret();
      test_irq_ret();
      test_soft_reset();
      final_report();
   end
endmodule
